//--- bench/mbse_exec_chk.sv
// Purpose: port-level assertions for the bit/skip/branch executor
// Assumes: hready is tied to hreadyout
// Notes:   bound to every mbse_exec instance
`timescale 1ns/1ps
`default_nettype none
`include "mbse_cfg.svh"
module mbse_exec_chk (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Status
  input wire logic        global_int_en,
  input wire logic        exec_busy
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic       take_a;
  logic       take_w;
  logic       take_i;
  logic [3:0] since_w_q;
  logic [3:0] since_i_q;
  assign take_a = hsel && htrans[1] && hready && hreadyout;
  assign take_w = take_a && hwrite;
  assign take_i = take_w && (haddr[7:0] == `MBSE_OFS_INSTR) && !exec_busy;
  // Saturating ages tie late effects to the write that caused them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      since_w_q <= 4'hF;
      since_i_q <= 4'hF;
    end else begin
      since_w_q <= take_w ? 4'h0 : since_w_q + {3'h0, since_w_q != 4'hF};
      since_i_q <= take_i ? 4'h0 : since_i_q + {3'h0, since_i_q != 4'hF};
    end
  end
  sequence s_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence s_busy_end;
    ##[1:2] !exec_busy;
  endsequence
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not OKAY");
  a_one_wait: assert property (take_a |=> s_wait)
    else $error("wait state not exactly one cycle");
  a_ready_back: assert property (!hreadyout |=> hreadyout)
    else $error("hreadyout low for more than one cycle");
  a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("hrdata changed without a completed transfer");
  a_busy_short: assert property ($rose(exec_busy) |-> s_busy_end)
    else $error("busy longer than two cycles");
  a_busy_follows: assert property (take_i |-> ##[2:6] exec_busy)
    else $error("instruction write did not raise busy");
  a_busy_cause: assert property ($rose(exec_busy) |-> since_i_q <= 4'h8)
    else $error("busy without an instruction write");
  a_gie_cause: assert property ($changed(global_int_en) |-> since_w_q <= 4'h8)
    else $error("interrupt enable changed without a write");
endmodule
bind mbse_exec mbse_exec_chk chk_u (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
  .hrdata, .hreadyout, .hresp, .global_int_en, .exec_busy
);
`default_nettype wire

//--- bench/tb.sv
// Purpose: register-level test of the bit/skip/branch executor
// Assumes: hready tied back from hreadyout
// Notes:   skip is seen as PC advancing by two
`timescale 1ns/1ps
`default_nettype none
`include "mbse_cfg.svh"
module tb;
  import mbse_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        global_int_en;
  logic        exec_busy;
  logic [31:0] q;
  int          err_total;
  int          check_count;
  mbse_exec dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .global_int_en(global_int_en), .exec_busy(exec_busy)
  );
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait for hready high at a rising edge
  task automatic wt();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
      if (n > 50) begin
        err_total++;
        finish_test();
      end
    end while (hreadyout !== 1'b1);
  endtask
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    wt();
    htrans <= 2'b00;
    hwdata <= d;
    wt();
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xf(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    xf(1'b0, a, 32'h0, r);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    rd(a, r);
    cmp(r, exp);
  endtask
  task automatic sm(input logic [7:0] a, input logic [7:0] v);
    wr(`MBSE_OFS_MADDR, {24'h0, a});
    wr(`MBSE_OFS_MDATA, {24'h0, v});
  endtask
  task automatic rm(input logic [7:0] a, input logic [7:0] v);
    wr(`MBSE_OFS_MADDR, {24'h0, a});
    rc(`MBSE_OFS_MDATA, {24'h0, v});
  endtask
  task automatic ex(input mbse_op_t op, input logic [2:0] b, input logic [13:0] a);
    logic [31:0] s;
    int n;
    wr(`MBSE_OFS_INSTR, {10'h0, a, b, op});
    n = 0;
    do begin
      rd(`MBSE_OFS_STATUS, s);
      n++;
    end while (s[`MBSE_ST_BUSY] !== 1'b0 && n < 20);
    while (exec_busy !== 1'b0 && n < 30) begin
      @(posedge hclk);
      n++;
    end
    if (s[`MBSE_ST_BUSY] !== 1'b0 || exec_busy !== 1'b0) begin
      err_total++;
      finish_test();
    end
  endtask
  // Runs one instruction and checks PC advance and the skip flag
  task automatic step(input mbse_op_t op, input logic [2:0] b, input logic [13:0] a,
                      input logic sk);
    logic [31:0] s;
    rd(`MBSE_OFS_PC, s);
    ex(op, b, a);
    rc(`MBSE_OFS_PC, {16'h0, s[15:0] + 16'h1 + {15'h0, sk}});
    rd(`MBSE_OFS_STATUS, s);
    cmp({31'h0, s[`MBSE_ST_SKIP]}, {31'h0, sk});
  endtask
  initial begin
    err_total = 0;
    check_count = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    rc(`MBSE_OFS_ACC, 32'h0);
    rc(`MBSE_OFS_FLAGS, 32'h0);
    rc(`MBSE_OFS_PC, 32'h0);
    wr(8'h20, 32'hFF);
    rc(8'h20, 32'h0);
    wr(`MBSE_OFS_CTRL, 32'h0);
    sm(8'h10, 8'h81);
    step(MBSE_ROT_ACC, 3'h0, 14'h10, 1'b0);
    rc(`MBSE_OFS_ACC, 32'h02);
    rc(`MBSE_OFS_FLAGS, 32'h1);
    rm(8'h10, 8'h81);
    step(MBSE_ROT_MEM, 3'h0, 14'h10, 1'b0);
    rm(8'h10, 8'h03);
    rc(`MBSE_OFS_ACC, 32'h02);
    sm(8'h11, 8'hFF);
    step(MBSE_BIT_CLR, 3'h7, 14'h11, 1'b0);
    rm(8'h11, 8'h7F);
    step(MBSE_BIT_SET, 3'h0, 14'h10, 1'b0);
    rm(8'h10, 8'h03);
    wr(`MBSE_OFS_CTRL, 32'h100);
    sm(8'h05, 8'h00);
    sm(8'h85, 8'h00);
    step(MBSE_B0_SET, 3'h2, 14'h05, 1'b0);
    rm(8'h05, 8'h04);
    rm(8'h85, 8'h00);
    step(MBSE_BIT_SET, 3'h2, 14'h05, 1'b0);
    rm(8'h85, 8'h04);
    step(MBSE_B0_CLR, 3'h2, 14'h05, 1'b0);
    rm(8'h05, 8'h00);
    step(MBSE_B0_TST1, 3'h2, 14'h05, 1'b0);
    step(MBSE_B0_TST0, 3'h2, 14'h05, 1'b1);
    step(MBSE_TST1, 3'h2, 14'h05, 1'b1);
    step(MBSE_TST0, 3'h2, 14'h05, 1'b0);
    step(MBSE_TST0, 3'h3, 14'h05, 1'b1);
    wr(`MBSE_OFS_CTRL, 32'h0);
    wr(`MBSE_OFS_ACC, 32'h40);
    step(MBSE_CMP_IMM, 3'h0, 14'h40, 1'b1);
    rc(`MBSE_OFS_FLAGS, 32'h3);
    step(MBSE_CMP_IMM, 3'h0, 14'h41, 1'b0);
    rc(`MBSE_OFS_FLAGS, 32'h0);
    sm(8'h20, 8'h30);
    step(MBSE_CMP_MEM, 3'h0, 14'h20, 1'b0);
    rc(`MBSE_OFS_FLAGS, 32'h1);
    rc(`MBSE_OFS_ACC, 32'h40);
    sm(8'h21, 8'hFF);
    step(MBSE_INC_ACC, 3'h0, 14'h21, 1'b1);
    rc(`MBSE_OFS_ACC, 32'h0);
    rm(8'h21, 8'hFF);
    step(MBSE_INC_MEM, 3'h0, 14'h21, 1'b1);
    rm(8'h21, 8'h00);
    step(MBSE_INC_MEM, 3'h0, 14'h21, 1'b0);
    step(MBSE_DEC_ACC, 3'h0, 14'h21, 1'b1);
    rc(`MBSE_OFS_ACC, 32'h0);
    step(MBSE_DEC_MEM, 3'h0, 14'h21, 1'b1);
    step(MBSE_DEC_MEM, 3'h0, 14'h21, 1'b0);
    rm(8'h21, 8'hFF);
    wr(`MBSE_OFS_CTRL, 32'h2);
    ex(MBSE_JUMP, 3'h0, 14'h1234);
    rc(`MBSE_OFS_PC, 32'h9234);
    ex(MBSE_CALL, 3'h0, 14'h0100);
    rc(`MBSE_OFS_PC, 32'h8100);
    rd(`MBSE_OFS_STATUS, q);
    cmp({28'h0, q[11:8]}, 32'h1);
    ex(MBSE_RET, 3'h0, 14'h0);
    rc(`MBSE_OFS_PC, 32'h9235);
    ex(MBSE_CALL, 3'h0, 14'h0100);
    ex(MBSE_IRET, 3'h0, 14'h0);
    rc(`MBSE_OFS_PC, 32'h9236);
    rc(`MBSE_OFS_FLAGS, 32'h5);
    cmp({31'h0, global_int_en}, 32'h1);
    // Return on an empty stack keeps the PC and flags underflow
    ex(MBSE_RET, 3'h0, 14'h0);
    rc(`MBSE_OFS_PC, 32'h9236);
    ex(mbse_op_t'(5'h1F), 3'h0, 14'h0);
    rc(`MBSE_OFS_STATUS, 32'h18);
    wr(`MBSE_OFS_STATUS, 32'h1C);
    rc(`MBSE_OFS_STATUS, 32'h0);
    // Reset in mid-run must bring back the reset values
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rc(`MBSE_OFS_FLAGS, 32'h0);
    rc(`MBSE_OFS_PC, 32'h0);
    cmp({31'h0, global_int_en}, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire

//--- verilog/mbse_alu.sv
// Purpose: combinational result, flag and skip logic per opcode
// Assumes: operand already fetched from the selected bank
// Notes:   no state
`timescale 1ns/1ps
`default_nettype none
module mbse_alu (
  // Operands
  input  wire mbse_pkg::mbse_op_t op,
  input  wire logic [7:0]         acc,
  input  wire logic [7:0]         mval,
  input  wire logic [7:0]         imm,
  input  wire logic [2:0]         bsel,
  input  wire logic               cin,
  // Results
  output logic [7:0]              res,
  output logic                    cout,
  output logic                    zout,
  output logic                    upd_flags,
  output logic                    upd_c,
  output logic                    skip,
  output logic                    wr_acc,
  output logic                    wr_mem
);
  import mbse_pkg::*;
  logic [7:0] mask;
  logic [8:0] diff;
  logic [7:0] opnd;
  logic [7:0] inc;
  logic [7:0] dec;
  logic       mbit;
  assign mask = 8'h01 << bsel;
  assign opnd = (op == MBSE_CMP_IMM) ? imm : mval;
  assign diff = {1'b0, acc} - {1'b0, opnd};
  assign inc  = mval + 8'h01;
  assign dec  = mval - 8'h01;
  assign mbit = |(mval & mask);

  always_comb begin
    res       = mval;
    cout      = cin;
    zout      = 1'b0;
    upd_flags = 1'b0;
    upd_c     = 1'b0;
    skip      = 1'b0;
    wr_acc    = 1'b0;
    wr_mem    = 1'b0;
    unique case (op)
      MBSE_ROT_ACC, MBSE_ROT_MEM: begin
        res    = {mval[6:0], cin};
        cout   = mval[7];
        upd_c  = 1'b1;
        wr_acc = (op == MBSE_ROT_ACC);
        wr_mem = (op == MBSE_ROT_MEM);
      end
      MBSE_BIT_CLR, MBSE_B0_CLR: begin
        res    = mval & ~mask;
        wr_mem = 1'b1;
      end
      MBSE_BIT_SET, MBSE_B0_SET: begin
        res    = mval | mask;
        wr_mem = 1'b1;
      end
      MBSE_CMP_IMM, MBSE_CMP_MEM: begin
        cout      = ~diff[8];
        zout      = (diff[7:0] == 8'h00);
        upd_flags = 1'b1;
        skip      = (acc == opnd);
      end
      MBSE_INC_ACC, MBSE_INC_MEM: begin
        res    = inc;
        skip   = (inc == 8'h00);
        wr_acc = (op == MBSE_INC_ACC);
        wr_mem = (op == MBSE_INC_MEM);
      end
      MBSE_DEC_ACC, MBSE_DEC_MEM: begin
        res    = dec;
        skip   = (dec == 8'h00);
        wr_acc = (op == MBSE_DEC_ACC);
        wr_mem = (op == MBSE_DEC_MEM);
      end
      MBSE_TST0, MBSE_B0_TST0: skip = ~mbit;
      MBSE_TST1, MBSE_B0_TST1: skip = mbit;
      default: res = mval;
    endcase
  end
endmodule
`default_nettype wire

//--- verilog/mbse_cfg.svh
// Purpose: offsets, field positions, reset values, cycle counts
// Assumes: byte addresses on a 32-bit AHB-Lite word map
// Notes:   definitions only
`ifndef MBSE_CFG_SVH
`define MBSE_CFG_SVH
`define MBSE_OFS_INSTR  8'h00
`define MBSE_OFS_ACC    8'h04
`define MBSE_OFS_FLAGS  8'h08
`define MBSE_OFS_PC     8'h0C
`define MBSE_OFS_CTRL   8'h10
`define MBSE_OFS_STATUS 8'h14
`define MBSE_OFS_MADDR  8'h18
`define MBSE_OFS_MDATA  8'h1C
`define MBSE_OP_LSB     0
`define MBSE_BIT_LSB    5
`define MBSE_ARG_LSB    8
`define MBSE_FLG_C      0
`define MBSE_FLG_Z      1
`define MBSE_FLG_GIE    2
`define MBSE_CTL_BANK   8
`define MBSE_ST_BUSY    0
`define MBSE_ST_SKIP    1
`define MBSE_ST_OVF     2
`define MBSE_ST_UNF     3
`define MBSE_ST_ILL     4
`define MBSE_ST_DEPTH   8
`define MBSE_RST_PC     16'h0000
`define MBSE_RST_ACC    8'h00
`define MBSE_RST_FLAGS  3'h0
`define MBSE_CYC_BASE   2'h1
`define MBSE_CYC_SKIP   2'h1
`define MBSE_CYC_BRANCH 2'h2
`endif

//--- verilog/mbse_exec.sv
// Purpose: bit, skip and branch instruction executor behind AHB-Lite
// Assumes: one AHB-Lite master, single word transfers
// Notes:   each transfer takes one wait state
// Operation
// - Rotate-left-through-carry result to accumulator only
// - In-place rotate writes memory back
// - Bit clear/set touches one bit
// - Bank-zero bit ops always use bank 0
// - Compare sets zero/carry, skips when equal
// - Increment to accumulator, skip on zero
// - Increment in place, skip on wrap
// - Decrement to acc or memory, skip zero
// - Test bit, skip when zero
// - Test bit, skip when one; bank-zero form
// - Jump: page bits plus 14-bit field
// - Call pushes PC plus one then jumps
// - Return pops PC; interrupt return sets enable
`timescale 1ns/1ps
`default_nettype none
`include "mbse_cfg.svh"
module mbse_exec #(
  parameter int STACK_DEPTH = 8,
  parameter int STACK_AW    = 3
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Core status
  output logic             global_int_en,
  output logic             exec_busy
);
  import mbse_pkg::*;

  // Bus phase capture
  logic [7:0]  a_q;
  logic        wr_q;
  logic        pend_q;
  logic        rdy_q;
  logic [31:0] rd_q;
  logic        take;
  assign take = hsel & htrans[1] & hready & ~pend_q;

  // Architectural state
  logic [7:0]  acc_q;
  logic [15:0] pc_q;
  logic        c_q;
  logic        z_q;
  logic        gie_q;
  logic [1:0]  page_q;
  logic        bank_q;
  logic [7:0]  maddr_q;
  logic [7:0]  dmem [256];

  // Executor state
  logic [4:0]  ir_op_q;
  logic [2:0]  ir_bit_q;
  logic [13:0] ir_arg_q;
  logic        go_q;
  logic [1:0]  cnt_q;
  logic        skip_q;
  logic        ovf_q;
  logic        unf_q;
  logic        ill_q;

  // Register decode
  logic hit_instr;
  logic hit_acc;
  logic hit_flags;
  logic hit_pc;
  logic hit_ctrl;
  logic hit_status;
  logic hit_maddr;
  logic hit_mdata;
  logic wdone;
  logic busy;
  assign wdone      = pend_q & wr_q;
  assign busy       = go_q | (cnt_q != 2'h0);
  assign hit_instr  = (a_q == `MBSE_OFS_INSTR);
  assign hit_acc    = (a_q == `MBSE_OFS_ACC);
  assign hit_flags  = (a_q == `MBSE_OFS_FLAGS);
  assign hit_pc     = (a_q == `MBSE_OFS_PC);
  assign hit_ctrl   = (a_q == `MBSE_OFS_CTRL);
  assign hit_status = (a_q == `MBSE_OFS_STATUS);
  assign hit_maddr  = (a_q == `MBSE_OFS_MADDR);
  assign hit_mdata  = (a_q == `MBSE_OFS_MDATA);

  // Software may not disturb state while an instruction runs
  logic sw_wr;
  assign sw_wr = wdone & ~busy;

  // Instruction decode
  mbse_op_t op;
  logic     op_legal;
  logic     bank0;
  logic     is_jump;
  logic     is_call;
  logic     is_ret;
  logic     is_iret;
  logic     branch;
  assign op_legal = (ir_op_q <= 5'h14);
  assign op       = op_legal ? mbse_op_t'(ir_op_q) : MBSE_NOP;
  assign bank0    = (op == MBSE_B0_CLR) | (op == MBSE_B0_SET) |
                    (op == MBSE_B0_TST0) | (op == MBSE_B0_TST1);
  assign is_jump  = (op == MBSE_JUMP);
  assign is_call  = (op == MBSE_CALL);
  assign is_iret  = (op == MBSE_IRET);
  assign is_ret   = (op == MBSE_RET) | is_iret;
  assign branch   = is_jump | is_call | is_ret;

  // Operand fetch
  logic [7:0] eff_addr;
  logic [7:0] mval;
  assign eff_addr = {bank0 ? 1'b0 : bank_q, ir_arg_q[6:0]};
  assign mval     = dmem[eff_addr];

  // Result unit
  logic [7:0] alu_res;
  logic       alu_c;
  logic       alu_z;
  logic       alu_upd_f;
  logic       alu_upd_c;
  logic       alu_skip;
  logic       alu_wacc;
  logic       alu_wmem;
  mbse_alu u_alu (
    .op        (op),
    .acc       (acc_q),
    .mval      (mval),
    .imm       (ir_arg_q[7:0]),
    .bsel      (ir_bit_q),
    .cin       (c_q),
    .res       (alu_res),
    .cout      (alu_c),
    .zout      (alu_z),
    .upd_flags (alu_upd_f),
    .upd_c     (alu_upd_c),
    .skip      (alu_skip),
    .wr_acc    (alu_wacc),
    .wr_mem    (alu_wmem)
  );

  // Return-address stack
  logic [15:0]       stk_top;
  logic              stk_full;
  logic              stk_empty;
  logic [STACK_AW:0] stk_lvl;
  logic              do_push;
  logic              do_pop;
  assign do_push = go_q & is_call;
  assign do_pop  = go_q & is_ret;
  mbse_stack #(
    .DEPTH (STACK_DEPTH),
    .AW    (STACK_AW)
  ) u_stk (
    .hclk    (hclk),
    .hresetn (hresetn),
    .push    (do_push),
    .pop     (do_pop),
    .din     (pc_q + 16'h0001),
    .top     (stk_top),
    .full    (stk_full),
    .empty   (stk_empty),
    .level   (stk_lvl)
  );

  // Next program counter
  logic [15:0] pc_seq;
  logic [15:0] pc_tgt;
  logic [15:0] pc_nx;
  assign pc_seq = pc_q + (alu_skip ? 16'h0002 : 16'h0001);
  assign pc_tgt = {page_q, ir_arg_q};
  assign pc_nx  = (is_jump | is_call) ? pc_tgt :
                  is_ret ? (stk_empty ? pc_q : stk_top) : pc_seq;

  // Total cycles of the instruction, the executing one included
  logic [1:0] cyc_tot;
  assign cyc_tot = branch ? `MBSE_CYC_BRANCH :
                   `MBSE_CYC_BASE + (alu_skip ? `MBSE_CYC_SKIP : 2'h0);

  // Read mux
  logic [31:0] rmux;
  assign rmux = hit_instr  ? {10'h0, ir_arg_q, ir_bit_q, ir_op_q} :
                hit_acc    ? {24'h0, acc_q} :
                hit_flags  ? {29'h0, gie_q, z_q, c_q} :
                hit_pc     ? {16'h0, pc_q} :
                hit_ctrl   ? {23'h0, bank_q, 6'h0, page_q} :
                hit_status ? {20'h0, 4'(stk_lvl), 3'h0, ill_q, unf_q,
                              ovf_q, skip_q, busy} :
                hit_maddr  ? {24'h0, maddr_q} :
                hit_mdata  ? {24'h0, dmem[maddr_q]} : 32'h0;

  // Bus handshake: address phase, one wait, then data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_q    <= 8'h00;
      wr_q   <= 1'b0;
      pend_q <= 1'b0;
      rdy_q  <= 1'b1;
      rd_q   <= 32'h0;
    end else if (take) begin
      a_q    <= haddr[7:0];
      wr_q   <= hwrite;
      pend_q <= 1'b1;
      rdy_q  <= 1'b0;
    end else if (pend_q) begin
      pend_q <= 1'b0;
      rdy_q  <= 1'b1;
      rd_q   <= wr_q ? 32'h0 : rmux;
    end
  end

  // Instruction launch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ir_op_q  <= 5'h00;
      ir_bit_q <= 3'h0;
      ir_arg_q <= 14'h0000;
      go_q     <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      go_q <= sw_wr & hit_instr;
      if (sw_wr & hit_instr) begin
        ir_op_q  <= hwdata[`MBSE_OP_LSB +: 5];
        ir_bit_q <= hwdata[`MBSE_BIT_LSB +: 3];
        ir_arg_q <= hwdata[`MBSE_ARG_LSB +: 14];
      end
      if (go_q) begin
        cnt_q <= cyc_tot - 2'h1;
      end else if (cnt_q != 2'h0) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end

  // Accumulator, flags, program counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= `MBSE_RST_ACC;
      pc_q  <= `MBSE_RST_PC;
      {gie_q, z_q, c_q} <= `MBSE_RST_FLAGS;
    end else if (go_q) begin
      pc_q <= pc_nx;
      if (alu_wacc) begin
        acc_q <= alu_res;
      end
      if (alu_upd_f) begin
        z_q <= alu_z;
      end
      if (alu_upd_f | alu_upd_c) begin
        c_q <= alu_c;
      end
      if (is_iret) begin
        gie_q <= 1'b1;
      end
    end else if (sw_wr) begin
      if (hit_acc) begin
        acc_q <= hwdata[7:0];
      end
      if (hit_pc) begin
        pc_q <= hwdata[15:0];
      end
      if (hit_flags) begin
        c_q   <= hwdata[`MBSE_FLG_C];
        z_q   <= hwdata[`MBSE_FLG_Z];
        gie_q <= hwdata[`MBSE_FLG_GIE];
      end
    end
  end

  // Page, bank and memory pointer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      page_q  <= 2'h0;
      bank_q  <= 1'b0;
      maddr_q <= 8'h00;
    end else if (sw_wr) begin
      if (hit_ctrl) begin
        page_q <= hwdata[1:0];
        bank_q <= hwdata[`MBSE_CTL_BANK];
      end
      if (hit_maddr) begin
        maddr_q <= hwdata[7:0];
      end
    end
  end

  // Sticky status, cleared only by writing one; skip is replaced at each launch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      skip_q <= 1'b0;
      ovf_q  <= 1'b0;
      unf_q  <= 1'b0;
      ill_q  <= 1'b0;
    end else if (go_q) begin
      skip_q <= alu_skip;
      ovf_q  <= ovf_q | (is_call & stk_full);
      unf_q  <= unf_q | (is_ret & stk_empty);
      ill_q  <= ill_q | ~op_legal;
    end else if (sw_wr & hit_status) begin
      ovf_q <= ovf_q & ~hwdata[`MBSE_ST_OVF];
      unf_q <= unf_q & ~hwdata[`MBSE_ST_UNF];
      ill_q <= ill_q & ~hwdata[`MBSE_ST_ILL];
    end
  end

  // Data memory: executor writes win over software in the same cycle
  always_ff @(posedge hclk) begin
    if (go_q & alu_wmem) begin
      dmem[eff_addr] <= alu_res;
    end else if (sw_wr & hit_mdata) begin
      dmem[maddr_q] <= hwdata[7:0];
    end
  end

  // Registered outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exec_busy     <= 1'b0;
      global_int_en <= 1'b0;
    end else begin
      exec_busy     <= busy;
      global_int_en <= gie_q;
    end
  end

  assign hrdata    = rd_q;
  assign hreadyout = rdy_q;
  assign hresp     = 1'b0;
endmodule
`default_nettype wire

//--- verilog/mbse_pkg.sv
// Purpose: shared types of the bit/skip/branch executor
// Assumes: nothing
// Notes:   opcode encoding is local to this block
package mbse_pkg;
  typedef enum logic [4:0] {
    MBSE_NOP      = 5'h00,
    MBSE_ROT_ACC  = 5'h01,
    MBSE_ROT_MEM  = 5'h02,
    MBSE_BIT_CLR  = 5'h03,
    MBSE_BIT_SET  = 5'h04,
    MBSE_B0_CLR   = 5'h05,
    MBSE_B0_SET   = 5'h06,
    MBSE_CMP_IMM  = 5'h07,
    MBSE_CMP_MEM  = 5'h08,
    MBSE_INC_ACC  = 5'h09,
    MBSE_INC_MEM  = 5'h0A,
    MBSE_DEC_ACC  = 5'h0B,
    MBSE_DEC_MEM  = 5'h0C,
    MBSE_TST0     = 5'h0D,
    MBSE_TST1     = 5'h0E,
    MBSE_B0_TST0  = 5'h0F,
    MBSE_B0_TST1  = 5'h10,
    MBSE_JUMP     = 5'h11,
    MBSE_CALL     = 5'h12,
    MBSE_RET      = 5'h13,
    MBSE_IRET     = 5'h14
  } mbse_op_t;
endpackage

//--- verilog/mbse_stack.sv
// Purpose: hardware return-address stack
// Assumes: push and pop never asserted together
// Notes:   push when full and pop when empty are dropped
`timescale 1ns/1ps
`default_nettype none
module mbse_stack #(
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  // Clock and reset
  input  wire logic          hclk,
  input  wire logic          hresetn,
  // Access
  input  wire logic          push,
  input  wire logic          pop,
  input  wire logic [15:0]   din,
  output logic      [15:0]   top,
  output logic               full,
  output logic               empty,
  output logic      [AW:0]   level
);
  logic [15:0] mem [DEPTH];
  logic [AW:0] lvl_q;
  logic [AW:0] lvl_d;
  logic [AW:0] top_ix;
  assign full   = (lvl_q == (AW+1)'(DEPTH));
  assign empty  = (lvl_q == '0);
  assign top_ix = lvl_q - (AW+1)'(1);
  assign top    = empty ? 16'h0000 : mem[top_ix[AW-1:0]];
  assign level  = lvl_q;
  assign lvl_d  = (push & ~full)  ? lvl_q + (AW+1)'(1) :
                  (pop  & ~empty) ? top_ix : lvl_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_q <= '0;
    end else begin
      lvl_q <= lvl_d;
    end
  end

  // Storage needs no reset; the level alone says what is valid
  always_ff @(posedge hclk) begin
    if (push & ~full) begin
      mem[lvl_q[AW-1:0]] <= din;
    end
  end
endmodule
`default_nettype wire
